// file: die_number_shifter.sv
// Serial shifter that presents the active die number on the data-out pin.
`timescale 1ns/10ps
module die_number_shifter #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic shift,
   output logic bit_out
);

   // -----------------------------------------------------------------
   // Shift state
   // -----------------------------------------------------------------
   logic [WIDTH-1:0] hold;        // Word being shifted out.
   logic [WIDTH-1:0] next_hold;   // Next word.
   logic next_bit_out;            // Next output bit.

   // Load takes the number; each falling clock edge presents the next bit, MSB first.
   // The word rotates so the number repeats while the frame stays open.
   always_comb begin
      next_hold = hold;
      next_bit_out = bit_out;
      if (load) begin
         next_hold = load_value;
      end else if (shift) begin
         next_bit_out = hold[WIDTH-1];
         next_hold = {hold[WIDTH-2:0], hold[WIDTH-1]};
      end
   end

   // Registers only.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hold <= '0;
         bit_out <= 1'b0;
      end else begin
         hold <= next_hold;
         bit_out <= next_bit_out;
      end
   end

endmodule : die_number_shifter

// file: spi_host.sv
// Serial host model that frames bytes and reads bits back.
`timescale 1ns/10ps
module spi_host (
   input wire logic clk_sys,
   input wire logic so,
   output logic cs_n,
   output logic sclk,
   output logic si
);
   // Each serial level lasts six system clocks.
   localparam int HALF = 6;
   // The lines rest with select high and clock low.
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // One serial bit; so is sampled late in the low phase.
   task automatic bitx(input logic v, output logic s);
      si = v;
      repeat (HALF) @(negedge clk_sys);
      s = so;
      sclk = 1'b1;
      repeat (HALF) @(negedge clk_sys);
      sclk = 1'b0;
   endtask : bitx
   // whole byte frames
   // Sends bytes MSB first, then clocks n more bits into r.
   task automatic frame(input logic [7:0] b [$], input int n, output logic [7:0] r);
      logic s;
      cs_n = 1'b0;
      foreach (b[i]) for (int k = 7; k >= 0; k--) bitx(b[i][k], s);
      repeat (n) begin
         bitx(~si, s);
         r = {r[6:0], s};
      end
      repeat (HALF) @(negedge clk_sys);
      cs_n = 1'b1;
      si = ~si;
      repeat (8) @(negedge clk_sys);
   endtask : frame
endmodule : spi_host

// file: wel_die_pkg.sv
// Constants, opcodes and decode functions of the write-enable and die-select logic.
package wel_die_pkg;

   // -----------------------------------------------------------------
   // Field widths and counts
   // -----------------------------------------------------------------
   localparam int BYTE_W = 8;                       // Bits per serial byte.
   localparam logic [2:0] BIT_LAST = 3'h7;          // Index of the last bit of a byte.
   localparam logic [2:0] BYTES_SAT = 3'h7;         // Saturation value of the byte counter.
   localparam logic [2:0] BYTES_ONE = 3'h1;         // Frame of opcode only.
   localparam logic [2:0] BYTES_TWO = 3'h2;         // Frame of opcode plus one byte.
   localparam logic [2:0] BYTES_THREE = 3'h3;       // Frame of opcode plus two bytes.
   localparam logic [7:0] DIE_RESET = 8'h00;        // Active die after power-up.

   // -----------------------------------------------------------------
   // Opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_WREN = 8'h06;          // Write enable.
   localparam logic [7:0] OP_VWREN = 8'h50;         // Volatile write enable.
   localparam logic [7:0] OP_WRDI = 8'h04;          // Write disable.
   localparam logic [7:0] OP_DIE_SEL = 8'hC2;       // Die select.
   localparam logic [7:0] OP_DIE_RD = 8'hF8;        // Read active die number.
   localparam logic [7:0] OP_WRSR1 = 8'h01;         // Status write, register 1 (and 2).
   localparam logic [7:0] OP_WRSR2 = 8'h31;         // Status write, register 2.
   localparam logic [7:0] OP_WRSR3 = 8'h11;         // Status write, register 3.
   localparam logic [7:0] OP_WR_EXT = 8'hC5;        // Extended address register write.

   // -----------------------------------------------------------------
   // Writable status bit positions held as volatile copies
   // -----------------------------------------------------------------
   localparam int SR1_STATUS_PROTECT_LO = 7;                     // Status protect low.
   localparam int SR1_BP_HI = 6;                    // Block protect 4.
   localparam int SR1_BP_LO = 2;                    // Block protect 0.
   localparam int SR2_CMP = 6;                      // Protect complement.
   localparam int SR2_QE = 1;                       // Quad enable.
   localparam int SR2_STATUS_PROTECT_HI = 0;                     // Status protect high.
   localparam int SR3_HOLD = 7;                     // Hold or reset pin select.
   localparam int SR3_DRIVE_STRENGTH_HI = 6;                     // Drive strength high bit.
   localparam int SR3_DRIVE_STRENGTH_LO = 5;                     // Drive strength low bit.
   localparam logic [7:0] SR1_MASK = 8'hFC;         // Volatile-writable bits of register 1.
   localparam logic [7:0] SR2_MASK = 8'h43;         // Volatile-writable bits of register 2.
   localparam logic [7:0] SR3_MASK = 8'hE0;         // Volatile-writable bits of register 3.

   // Receiver modes of the serial front end.
   typedef enum logic [1:0] {MODE_IDLE, MODE_RX, MODE_OUT} mode_t;

   // Program, erase and protection opcodes that need the ordinary latch.
   function automatic logic latch_gated(input logic [7:0] op);
      case (op)
         8'h02, 8'h12, 8'h32, 8'h34: latch_gated = 1'b1;
         8'h20, 8'h21, 8'hD8, 8'h60, 8'hC7: latch_gated = 1'b1;
         8'h52, 8'h5C, 8'hDC: latch_gated = 1'b1;
         8'h36, 8'h39, 8'hA8, 8'hA9: latch_gated = 1'b1;
         8'h44, 8'h42, 8'h2C, 8'hA6, 8'hE3, 8'hE4: latch_gated = 1'b1;
         8'h7E, 8'h98, 8'h28, 8'h29: latch_gated = 1'b1;
         default: latch_gated = 1'b0;
      endcase
   endfunction : latch_gated

   // Status register write opcodes.
   function automatic logic status_write(input logic [7:0] op);
      status_write = (op == OP_WRSR1) || (op == OP_WRSR2) || (op == OP_WRSR3);
   endfunction : status_write

endpackage : wel_die_pkg

// file: write_enable_and_die_select.sv
// Command gating, write-enable state and die selection of one stacked die.
`timescale 1ns/10ps
module write_enable_and_die_select #(
   parameter logic [7:0] DIE_NUMBER = 8'h00
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic op_done,
   input wire logic sw_reset,
   input wire logic [7:0] nv_status1,
   input wire logic [7:0] nv_status2,
   input wire logic [7:0] nv_status3,
   output logic write_enable_latch,
   output logic volatile_pending,
   output logic [7:0] active_die,
   output logic die_is_active,
   output logic cmd_accept,
   output logic [7:0] cmd_opcode,
   output logic [7:0] cmd_arg1,
   output logic [7:0] cmd_arg2,
   output logic [2:0] cmd_nbytes,
   output logic [7:0] vol_status1,
   output logic [7:0] vol_status2,
   output logic [7:0] vol_status3
);

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic [1:0] cs_sync;      // Chip select, two stages.
   logic [1:0] sclk_sync;    // Serial clock, two stages.
   logic [1:0] si_sync;      // Serial input, two stages.
   logic cs_last;            // Synchronised chip select, one cycle late.
   logic sclk_last;          // Synchronised serial clock, one cycle late.

   // Only the second stage is read by the logic.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_sync <= 2'h3;
         sclk_sync <= 2'h0;
         si_sync <= 2'h0;
         cs_last <= 1'b1;
         sclk_last <= 1'b0;
      end else begin
         cs_sync <= {cs_sync[0], cs_n};
         sclk_sync <= {sclk_sync[0], sclk};
         si_sync <= {si_sync[0], si};
         cs_last <= cs_sync[1];
         sclk_last <= sclk_sync[1];
      end
   end

   logic cs_low;       // Frame open.
   logic sclk_rise;    // Rising serial clock edge inside the frame.
   logic sclk_fall;    // Falling serial clock edge inside the frame.
   logic cs_rise;      // Frame just closed.
   assign cs_low = !cs_sync[1];
   assign sclk_rise = cs_low && sclk_sync[1] && !sclk_last;
   assign sclk_fall = cs_low && !sclk_sync[1] && sclk_last;
   assign cs_rise = cs_sync[1] && !cs_last;

   // -----------------------------------------------------------------
   // Serial receiver
   // -----------------------------------------------------------------
   wel_die_pkg::mode_t mode;        // Receiver mode.
   wel_die_pkg::mode_t next_mode;   // Next mode.
   logic [2:0] bit_cnt;             // Bits of the current byte.
   logic [2:0] next_bit_cnt;
   logic [2:0] byte_cnt;            // Whole bytes of the frame, saturating.
   logic [2:0] next_byte_cnt;
   logic [7:0] shreg;               // Input shift register.
   logic [7:0] next_shreg;
   logic [7:0] opcode;              // First byte of the frame.
   logic [7:0] next_opcode;
   logic [7:0] arg1;                // Second byte.
   logic [7:0] next_arg1;
   logic [7:0] arg2;                // Third byte.
   logic [7:0] next_arg2;
   logic shift_load;                // Load of the die number shifter.
   logic [7:0] full_byte;           // Byte completed by this edge.

   // Bits arrive MSB first on rising edges; a closed frame clears the counters.
   always_comb begin
      next_mode = mode;
      next_bit_cnt = bit_cnt;
      next_byte_cnt = byte_cnt;
      next_shreg = shreg;
      next_opcode = opcode;
      next_arg1 = arg1;
      next_arg2 = arg2;
      shift_load = 1'b0;
      full_byte = {shreg[6:0], si_sync[1]};
      case (mode)
         wel_die_pkg::MODE_IDLE: begin
            next_bit_cnt = '0;
            next_byte_cnt = '0;
            if (cs_low) begin
               next_mode = wel_die_pkg::MODE_RX;
            end
         end
         wel_die_pkg::MODE_RX: begin
            if (!cs_low) begin
               next_mode = wel_die_pkg::MODE_IDLE;
            end else if (sclk_rise) begin
               next_shreg = full_byte;
               next_bit_cnt = bit_cnt + 3'h1;
               if (bit_cnt == wel_die_pkg::BIT_LAST) begin
                  if (byte_cnt != wel_die_pkg::BYTES_SAT) begin
                     next_byte_cnt = byte_cnt + 3'h1;
                  end
                  if (byte_cnt == 3'h0) begin
                     next_opcode = full_byte;
                     if (full_byte == wel_die_pkg::OP_DIE_RD && die_is_active) begin
                        next_mode = wel_die_pkg::MODE_OUT;
                        shift_load = 1'b1;
                     end
                  end else if (byte_cnt == wel_die_pkg::BYTES_ONE) begin
                     next_arg1 = full_byte;
                  end else if (byte_cnt == wel_die_pkg::BYTES_TWO) begin
                     next_arg2 = full_byte;
                  end
               end
            end
         end
         wel_die_pkg::MODE_OUT: begin
            if (!cs_low) begin
               next_mode = wel_die_pkg::MODE_IDLE;
            end
         end
         default: begin
            next_mode = wel_die_pkg::MODE_IDLE;
         end
      endcase
   end

   // Registers only.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode <= wel_die_pkg::MODE_IDLE;
         bit_cnt <= '0;
         byte_cnt <= '0;
         shreg <= '0;
         opcode <= '0;
         arg1 <= '0;
         arg2 <= '0;
         so_oe <= 1'b0;
      end else begin
         mode <= next_mode;
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         shreg <= next_shreg;
         opcode <= next_opcode;
         arg1 <= next_arg1;
         arg2 <= next_arg2;
         so_oe <= (next_mode == wel_die_pkg::MODE_OUT);
      end
   end

   // Shifter that drives the data-out pin, one bit per falling edge.
   die_number_shifter #(.WIDTH(wel_die_pkg::BYTE_W)) u_shift (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(shift_load),
      .load_value(active_die),
      .shift(sclk_fall && mode == wel_die_pkg::MODE_OUT),
      .bit_out(so)
   );

   // -----------------------------------------------------------------
   // Enable state, die selection and command issue
   // -----------------------------------------------------------------
   logic exec;              // Frame closed on a byte boundary.
   logic loaded;            // Volatile copies hold the stored values.
   logic next_wel, next_vol, next_loaded, next_active, next_accept;
   logic [7:0] next_die;
   logic [7:0] next_vs1, next_vs2, next_vs3;
   logic [7:0] next_cop, next_ca1, next_ca2;
   logic [2:0] next_cnb;
   logic sr_len_ok;         // Status write carried the right number of bytes.

   assign exec = cs_rise && (bit_cnt == 3'h0) && (byte_cnt != 3'h0);
   assign sr_len_ok = (byte_cnt == wel_die_pkg::BYTES_TWO) ||
      (opcode == wel_die_pkg::OP_WRSR1 && byte_cnt == wel_die_pkg::BYTES_THREE);

   // Completion and resets clear first; a command closing in the same cycle wins.
   always_comb begin
      next_wel = write_enable_latch;
      next_vol = volatile_pending;
      next_loaded = loaded;
      next_die = active_die;
      next_vs1 = vol_status1;
      next_vs2 = vol_status2;
      next_vs3 = vol_status3;
      next_accept = 1'b0;
      next_cop = cmd_opcode;
      next_ca1 = cmd_arg1;
      next_ca2 = cmd_arg2;
      next_cnb = cmd_nbytes;
      if (op_done || sw_reset) begin
         next_wel = 1'b0;
      end
      if (!loaded || sw_reset) begin
         next_vol = 1'b0;
         next_loaded = 1'b1;
         next_vs1 = nv_status1 & wel_die_pkg::SR1_MASK;
         next_vs2 = nv_status2 & wel_die_pkg::SR2_MASK;
         next_vs3 = nv_status3 & wel_die_pkg::SR3_MASK;
      end
      if (exec && opcode == wel_die_pkg::OP_DIE_SEL) begin
         if (byte_cnt == wel_die_pkg::BYTES_TWO) begin
            next_die = arg1;
         end
      end else if (exec && die_is_active) begin
         case (opcode)
            wel_die_pkg::OP_WREN: begin
               if (byte_cnt == wel_die_pkg::BYTES_ONE && !volatile_pending) begin
                  next_wel = 1'b1;
               end
            end
            wel_die_pkg::OP_VWREN: begin
               if (byte_cnt == wel_die_pkg::BYTES_ONE && !write_enable_latch) begin
                  next_vol = 1'b1;
               end
            end
            wel_die_pkg::OP_WRDI: begin
               if (byte_cnt == wel_die_pkg::BYTES_ONE) begin
                  next_wel = 1'b0;
                  next_vol = 1'b0;
               end
            end
            wel_die_pkg::OP_WR_EXT: begin
               if (byte_cnt == wel_die_pkg::BYTES_TWO && write_enable_latch) begin
                  next_accept = 1'b1;
               end
            end
            default: begin
               if (wel_die_pkg::status_write(opcode) && sr_len_ok) begin
                  if (volatile_pending) begin
                     next_vol = 1'b0;
                     if (opcode == wel_die_pkg::OP_WRSR1) begin
                        next_vs1 = arg1 & wel_die_pkg::SR1_MASK;
                        if (byte_cnt == wel_die_pkg::BYTES_THREE) begin
                           next_vs2 = arg2 & wel_die_pkg::SR2_MASK;
                        end
                     end else if (opcode == wel_die_pkg::OP_WRSR2) begin
                        next_vs2 = arg1 & wel_die_pkg::SR2_MASK;
                     end else begin
                        next_vs3 = arg1 & wel_die_pkg::SR3_MASK;
                     end
                  end else if (write_enable_latch) begin
                     next_accept = 1'b1;
                  end
               end
               if (wel_die_pkg::latch_gated(opcode) && write_enable_latch) begin
                  next_accept = 1'b1;
               end
            end
         endcase
      end
      if (next_accept) begin
         next_cop = opcode;
         next_ca1 = arg1;
         next_ca2 = arg2;
         next_cnb = byte_cnt;
      end
      next_active = (next_die == DIE_NUMBER);
   end

   // Registers only; the die number returns to zero only at power-up reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         write_enable_latch <= 1'b0;
         volatile_pending <= 1'b0;
         loaded <= 1'b0;
         active_die <= wel_die_pkg::DIE_RESET;
         die_is_active <= (wel_die_pkg::DIE_RESET == DIE_NUMBER);
         vol_status1 <= '0;
         vol_status2 <= '0;
         vol_status3 <= '0;
         cmd_accept <= 1'b0;
         cmd_opcode <= '0;
         cmd_arg1 <= '0;
         cmd_arg2 <= '0;
         cmd_nbytes <= '0;
      end else begin
         write_enable_latch <= next_wel;
         volatile_pending <= next_vol;
         loaded <= next_loaded;
         active_die <= next_die;
         die_is_active <= next_active;
         vol_status1 <= next_vs1;
         vol_status2 <= next_vs2;
         vol_status3 <= next_vs3;
         cmd_accept <= next_accept;
         cmd_opcode <= next_cop;
         cmd_arg1 <= next_ca1;
         cmd_arg2 <= next_ca2;
         cmd_nbytes <= next_cnb;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_wren_sets;
      @(posedge clk_sys) disable iff (rst)
         exec && die_is_active && opcode == wel_die_pkg::OP_WREN &&
         byte_cnt == wel_die_pkg::BYTES_ONE && !volatile_pending |=> write_enable_latch;
   endproperty
   a_wren_sets: assert property (p_wren_sets) else $error("write enable did not set latch");

   property p_wren_refused;
      @(posedge clk_sys) disable iff (rst)
         volatile_pending && !write_enable_latch |=> !write_enable_latch;
   endproperty
   a_wren_refused: assert property (p_wren_refused) else $error("latch set under volatile enable");

   property p_vwren_refused;
      @(posedge clk_sys) disable iff (rst)
         write_enable_latch && !volatile_pending |=> !volatile_pending;
   endproperty
   a_vwren_refused: assert property (p_vwren_refused) else $error("volatile enable under latch");

   property p_wrdi;
      @(posedge clk_sys) disable iff (rst)
         exec && die_is_active && opcode == wel_die_pkg::OP_WRDI &&
         byte_cnt == wel_die_pkg::BYTES_ONE |=> !write_enable_latch && !volatile_pending;
   endproperty
   a_wrdi: assert property (p_wrdi) else $error("write disable left an enable set");

   property p_die_sel;
      @(posedge clk_sys) disable iff (rst)
         exec && opcode == wel_die_pkg::OP_DIE_SEL && byte_cnt == wel_die_pkg::BYTES_TWO
         |=> active_die == $past(arg1) ##1 die_is_active == (active_die == DIE_NUMBER);
   endproperty
   a_die_sel: assert property (p_die_sel) else $error("die select not taken");

   property p_accept_gated;
      @(posedge clk_sys) disable iff (rst)
         $rose(cmd_accept) |-> $past(write_enable_latch) && $past(exec);
   endproperty
   a_accept_gated: assert property (p_accept_gated) else $error("command accepted without latch");

   property p_done_clears;
      @(posedge clk_sys) disable iff (rst)
         op_done && !exec |=> !write_enable_latch;
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("latch not cleared on completion");

   property p_power_die;
      @(posedge clk_sys) disable iff (rst)
         $past(rst) |-> active_die == wel_die_pkg::DIE_RESET;
   endproperty
   a_power_die: assert property (p_power_die) else $error("die zero not active after reset");

   property p_vol_only;
      @(posedge clk_sys) disable iff (rst)
         $rose(volatile_pending) |-> !write_enable_latch;
   endproperty
   a_vol_only: assert property (p_vol_only) else $error("volatile enable set the latch");

endmodule : write_enable_and_die_select

// file: write_enable_and_die_select_tb.sv
// Self-checking bench of the write-enable and die-select block.
`timescale 1ns/10ps
module write_enable_and_die_select_tb;
   logic clk_sys = 0, rst = 1, op_done = 0, sw_reset = 0;
   logic [7:0] nv1, nv2, nv3, v1, v2, v3, die = 0, rd;
   logic [15:0] lf = 16'h0139; // Random source state.
   wire cs_n, sclk, si, so, so_oe, wel_o, vp_o, dia, acc_o;
   wire [7:0] ad, op_o, s1, s2, s3, a1_o, a2_o;
   wire [2:0] nb_o;
   int fail_count = 0, comparisons = 0, acc = 0, wel = 0, vol = 0;
   logic oe_seen = 0;
   always #50 clk_sys = ~clk_sys;
   // Counts accept pulses and notes any drive of so.
   always @(posedge clk_sys) begin
      if (acc_o === 1'b1) acc++;
      if (so_oe === 1'b1) oe_seen = 1;
   end
   spi_host spi_host_inst (.clk_sys(clk_sys), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si));
   write_enable_and_die_select write_enable_and_die_select_inst (.clk_sys(clk_sys),
      .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
      .op_done(op_done), .sw_reset(sw_reset), .nv_status1(nv1), .nv_status2(nv2),
      .nv_status3(nv3), .write_enable_latch(wel_o), .volatile_pending(vp_o),
      .active_die(ad), .die_is_active(dia), .cmd_accept(acc_o), .cmd_opcode(op_o),
      .cmd_arg1(a1_o), .cmd_arg2(a2_o), .cmd_nbytes(nb_o), .vol_status1(s1), .vol_status2(s2),
      .vol_status3(s3));
   function automatic logic [7:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction : rnd
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      if (fail_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   // Sends one frame and updates the reference state.
   task automatic cmd(input logic [7:0] b [$]);
      int a0;
      logic g;
      a0 = acc;
      g = 0;
      spi_host_inst.frame(b, 0, rd);
      if (die == 8'h00 || b[0] == 8'hC2) case (b[0])
         8'h06: if (vol == 0) wel = 1;
         8'h50: if (wel == 0) vol = 1;
         8'h04: {wel, vol} = 0;
         8'hC2: die = b[1];
         8'h01, 8'h31, 8'h11: if (vol == 1) begin
            if (b[0] == 8'h01) v1 = b[1] & 8'hFC;
            if (b[0] == 8'h31) v2 = b[1] & 8'h43;
            if (b.size() == 3) v2 = b[2] & 8'h43;
            if (b[0] == 8'h11) v3 = b[1] & 8'hE0;
            vol = 0;
         end else g = (wel == 1);
         default: g = (wel == 1) && (b[0] inside {8'h02, 8'h12, 8'h32, 8'h20, 8'hD8,
            8'h60, 8'hC7, 8'h52, 8'h5C, 8'hDC, 8'h36, 8'h39, 8'hA8, 8'hA9, 8'hC5});
      endcase
      chk(wel_o, wel);
      chk(vp_o, vol);
      chk(acc - a0, g);
      if (g) chk(op_o, b[0]);
      if (g && b.size() > 1) chk(a1_o, b[1]);
      if (g && b.size() > 2) chk(a2_o, b[2]);
      if (g) chk(nb_o, 8'(b.size()));
      chk(s1, v1);
      chk(s2, v2);
      chk(s3, v3);
      chk(ad, die);
      chk(dia, die == 8'h00);
   endtask : cmd
   // Pulses a done or reset strobe for one clock.
   task automatic pulse(input logic r);
      if (r) sw_reset = 1;
      else op_done = 1;
      @(negedge clk_sys);
      {op_done, sw_reset} = 0;
      wel = 0;
      if (r) vol = 0;
      if (r) {v1, v2, v3} = {nv1 & 8'hFC, nv2 & 8'h43, nv3 & 8'hE0};
      @(negedge clk_sys);
      chk(wel_o, 0);
      chk({s1, s2, s3} == {v1, v2, v3}, 1);
   endtask : pulse
   initial begin
      repeat (60000) @(posedge clk_sys);
      fail_count++;
      conclude();
   end
   initial begin
      logic [7:0] q [$];
      static logic [7:0] ops [15] = '{8'h02, 8'h12, 8'h32, 8'h20, 8'hD8, 8'h60, 8'hC7, 8'h52,
         8'h5C, 8'hDC, 8'h36, 8'h39, 8'hA8, 8'hA9, 8'hC5};
      {nv1, nv2, nv3} = {rnd(), rnd(), rnd()};
      {v1, v2, v3} = {nv1 & 8'hFC, nv2 & 8'h43, nv3 & 8'hE0};
      repeat (12) @(negedge clk_sys);
      rst = 0;
      repeat (3) @(negedge clk_sys);
      chk(ad, 8'h00);
      cmd({8'h02, rnd(), rnd(), rnd()});
      cmd({8'h06});
      cmd({8'h50});
      foreach (ops[i]) begin
         q = {ops[i]};
         repeat ((ops[i] == 8'hC5) ? 1 : (ops[i] inside {8'h60, 8'hC7}) ? 0 : 3)
            q.push_back(rnd());
         cmd({8'h06});
         cmd(q);
         oe_seen = 0;
         spi_host_inst.frame({8'hF8}, 8, rd);
         chk(rd, die);
         chk(oe_seen, 1);
         pulse(0);
      end
      cmd({8'h06});
      cmd({8'h01, rnd()});
      pulse(0);
      cmd({8'h04});
      cmd({8'h50});
      cmd({8'h06});
      cmd({8'h01, rnd(), rnd()});
      cmd({8'h50});
      cmd({8'h11, rnd()});
      cmd({8'h50});
      cmd({8'h31, rnd()});
      cmd({8'h50});
      cmd({8'h04});
      cmd({8'h06});
      cmd({8'h04});
      {nv1, nv2, nv3} = {rnd(), rnd(), rnd()};
      pulse(1);
      // deselected die keeps its latch and leaves so undriven while another die is selected.
      cmd({8'h06});
      cmd({8'h20, rnd(), rnd(), rnd()});
      cmd({8'hC2, 8'h03});
      oe_seen = 0;
      spi_host_inst.frame({8'hF8}, 8, rd);
      chk(oe_seen, 0);
      pulse(0);
      cmd({8'h06});
      cmd({8'hC2, 8'h00});
      conclude();
   end
endmodule : write_enable_and_die_select_tb
